/* hw/atadi_consts.vh */
// Contract
// - data bus is 16 bits; registers use low 8 lines, data uses all 16.
// - first chip select plus address picks command block; reads and writes share slots.
// - second chip select picks alternate status, device control or drive address.
// - write strobe rising edge captures bus into addressed or data register.
// - read strobe low drives addressed register; host latches on rising edge.
// - interrupt driven only when drive selected and interrupts enabled, else floats.
// - pending interrupt clears on status read or command write.
// - device 1 asserts presence within 400 ms; device 0 waits 450 ms.
// - device 1 releases presence on first valid command; then activity indication.
// - after reset device 1 releases diagnostic within 1 ms, asserts within 30 s.
// - diagnostics command: device 1 releases diagnostic; device 0 waits 6 s; device 0 here does not wait, pdiag is only read back at drive address.
// - no device 1 presence: device 0 posts status, zeroes device 1 status.
// - cable select low means master, open or high means slave.
// - device pulls ready low at strobe falling edge when wait needed.
// - device raises DMA request when ready; host acknowledges.
// - data-out bursts latch 16-bit bus on both host strobe edges.
// - device holds its ready asserted in data-out bursts while it can accept.
// - data-in bursts: device toggles strobe, one word per edge; may pause.
// - busy clears within 9.5 us after reset release.
// - strobe, ready and stop lines take burst meanings while acknowledge held.
`ifndef ATADI_CONSTS_VH
`define ATADI_CONSTS_VH
`define ATADI_CLK_HZ        10000000
`define ATADI_T_BSY_NS      9500
`define ATADI_SYNC_LAT      5
`define ATADI_T_PRES_MS     400
`define ATADI_T_WAITP_MS    450
`define ATADI_T_DIAGREL_MS  1
`define ATADI_A_DATA        3'h0
`define ATADI_A_ERRFEAT     3'h1
`define ATADI_A_SECCNT      3'h2
`define ATADI_A_SECNUM      3'h3
`define ATADI_A_CYLLO       3'h4
`define ATADI_A_CYLHI       3'h5
`define ATADI_A_DRVHD       3'h6
`define ATADI_A_STATCMD     3'h7
`define ATADI_A_ALTCTL      3'h6
`define ATADI_A_DRVADR      3'h7
`define ATADI_B_DEV         4
`define ATADI_B_NIEN        1
`define ATADI_B_SRST        2
`define ATADI_B_BSY         7
`define ATADI_B_DRDY        6
`define ATADI_B_DRQ         3
`define ATADI_CMD_DIAG      8'h90
`define ATADI_STAT_ZERO     8'h00
`endif

/* hw/atadi_sync.v */
`timescale 1ns/10ps
module atadi_sync #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire [W-1:0] d,
   output reg  [W-1:0] q
);
   reg [W-1:0] meta_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= {W{1'b0}};
         q       <= {W{1'b0}};
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule // atadi_sync

/* hw/atadi_timer.v */
`timescale 1ns/10ps
// down counter; done pulses once when a loaded count expires
module atadi_timer #(
   parameter W = 32
) (
   input  wire         clk,
   input  wire         rst_n,
   input  wire         load,
   input  wire [W-1:0] count,
   output reg          busy,
   output reg          done
);
   reg [W-1:0] cnt_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= {W{1'b0}};
         busy   <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (load) begin
            cnt_ff <= count;
            busy   <= 1'b1;
         end else if (busy) begin
            if (cnt_ff <= {{(W-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // atadi_timer

/* hw/atadi_top.v */
`timescale 1ns/10ps
`include "atadi_consts.vh"
module atadi_top #(
   parameter [31:0] PRES_CYC  = (`ATADI_T_PRES_MS * (`ATADI_CLK_HZ / 1000)),
   parameter [31:0] WAITP_CYC = (`ATADI_T_WAITP_MS * (`ATADI_CLK_HZ / 1000)),
   parameter [31:0] DREL_CYC  = (`ATADI_T_DIAGREL_MS * (`ATADI_CLK_HZ / 1000)),
   parameter [31:0] DIAG_CYC  = 32'h0000_0400
) (
   // clock, reset
   input  wire        I_CLK,
   input  wire        I_RESETN,
   // host cable, all asynchronous
   input  wire        I_PIN_RESETN,
   input  wire [15:0] I_DD,
   output reg  [15:0] O_DD,
   output reg         O_DD_OE,
   input  wire [2:0]  I_DA,
   input  wire        I_CS0N,
   input  wire        I_CS1N,
   input  wire        I_DIOWN,
   input  wire        I_DIORN,
   input  wire        I_DMACKN,
   input  wire        I_CSEL,
   output reg         O_IORDY,
   output reg         O_IORDY_OE,
   output reg         O_INTRQ,
   output reg         O_INTRQ_OE,
   output reg         O_DMARQ,
   input  wire        I_DASPN,
   output reg         O_DASP_OE,
   input  wire        I_PDIAGN,
   output reg         O_PDIAG_OE,
   // drive processor side
   input  wire        I_CSEL_MODE,
   input  wire        I_IRQ_SET,
   input  wire        I_CMD_ACCEPT,
   input  wire        I_ACTIVE,
   input  wire        I_DIAG_DONE,
   input  wire        I_WAIT,
   input  wire        I_DMA_RDY,
   input  wire        I_UDMA_EN,
   input  wire        I_UDMA_IN,
   input  wire [15:0] I_RD_DATA,
   input  wire [7:0]  I_STATUS,
   input  wire [7:0]  I_ERROR,
   output reg         O_IS_MASTER,
   output reg         O_DEV1_ABSENT,
   output reg         O_BUSY,
   output reg         O_DATA_WR,
   output reg         O_DATA_RD,
   output reg         O_UDMA_STB,
   output reg         O_UDMA_STOP,
   output reg  [15:0] O_WR_DATA,
   output reg  [7:0]  O_CMD,
   output reg         O_CMD_STB,
   output reg  [7:0]  O_DEV1_STAT,
   output reg  [7:0]  O_FEAT,
   output reg  [7:0]  O_DEVCTL
);
////////////////////////////////////////////////////////////////////////////
   wire [15:0] dd_s;
   wire [2:0]  da_s;
   wire        rstp_s, cs0_s, cs1_s, iow_s, ior_s, ack_s, csel_s;
   wire        dasp_s, pdiag_s;
   atadi_sync #(.W(16)) u_sdd (.clk(I_CLK), .rst_n(I_RESETN),
      .d(I_DD), .q(dd_s));
   atadi_sync #(.W(13)) u_sctl (.clk(I_CLK), .rst_n(I_RESETN),
      .d({I_DA, I_PIN_RESETN, ~I_CS0N, ~I_CS1N, ~I_DIOWN, ~I_DIORN,
          ~I_DMACKN, I_CSEL, ~I_DASPN, ~I_PDIAGN}),
      .q({da_s, rstp_s, cs0_s, cs1_s, iow_s, ior_s, ack_s, csel_s,
          dasp_s, pdiag_s}));
   reg  iow_d_ff, ior_d_ff, rstp_d_ff;
   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         iow_d_ff  <= 1'b0;
         ior_d_ff  <= 1'b0;
         rstp_d_ff <= 1'b0;
      end else begin
         iow_d_ff  <= iow_s;
         ior_d_ff  <= ior_s;
         rstp_d_ff <= rstp_s;
      end
   end
   // in udma the write strobe is stop and read strobe is host strobe on data-out, host ready on data-in
   wire udma     = ack_s & I_UDMA_EN;
   wire iow_fall = iow_s & ~iow_d_ff & ~udma;
   wire iow_rise = ~iow_s & iow_d_ff & ~udma;
   wire ior_fall = ior_s & ~ior_d_ff & ~udma;
   wire ior_rise = ~ior_s & ior_d_ff & ~udma;
   wire hstb_edg = (ior_s ^ ior_d_ff) & udma & ~I_UDMA_IN;
   wire rst_rel  = rstp_s & ~rstp_d_ff;
   wire in_rst   = ~rstp_s;
////////////////////////////////////////////////////////////////////////////
   // strap sampled after release, never under async reset
   reg master_ff, irq_ff, dev1_seen_ff, first_cmd_ff, pres_win_ff;
   reg pdiag_drv_ff, srst_d_ff, busy_ff;
   reg [7:0] devctl_ff;
   // device select lives in the drive/head register
   reg       drvhd_dev_ff;
   wire      sel_dev = (drvhd_dev_ff == ~master_ff);
   wire      drvhd_wr = iow_rise & cs0_s & ~cs1_s &
                        (da_s == `ATADI_A_DRVHD);
   wire      cmd_wr  = iow_rise & cs0_s & ~cs1_s &
                       (da_s == `ATADI_A_STATCMD);
   wire      stat_rd = ior_rise & cs0_s & ~cs1_s &
                       (da_s == `ATADI_A_STATCMD);
   wire      ctl_wr  = iow_rise & cs1_s & ~cs0_s &
                       (da_s == `ATADI_A_ALTCTL);
   wire      srst_now = devctl_ff[`ATADI_B_SRST];
   wire      srst_rel = srst_d_ff & ~srst_now;
   wire      any_rel  = rst_rel | srst_rel;
   wire      diag_cmd = cmd_wr & (dd_s[7:0] == `ATADI_CMD_DIAG);
   wire      bsy_done, pres_done, drel_done, diag_done, wp_done;
   wire      bsy_busy, pres_busy, wp_busy;
   localparam [31:0] BSY_CYC =
      // pin sync and edge detect eat part of the budget
      (`ATADI_T_BSY_NS / (1000000000 / `ATADI_CLK_HZ)) -
      `ATADI_SYNC_LAT;
   atadi_timer u_tbsy (.clk(I_CLK), .rst_n(I_RESETN), .load(any_rel),
      .count(BSY_CYC), .busy(bsy_busy), .done(bsy_done));
   atadi_timer u_tpres (.clk(I_CLK), .rst_n(I_RESETN), .load(rst_rel),
      .count(PRES_CYC), .busy(pres_busy), .done(pres_done));
   atadi_timer u_twait (.clk(I_CLK), .rst_n(I_RESETN), .load(rst_rel),
      .count(WAITP_CYC), .busy(wp_busy), .done(wp_done));
   atadi_timer u_tdrel (.clk(I_CLK), .rst_n(I_RESETN),
      .load(any_rel | diag_cmd), .count(DREL_CYC), .busy(),
      .done(drel_done));
   atadi_timer u_tdiag (.clk(I_CLK), .rst_n(I_RESETN),
      .load(drel_done), .count(DIAG_CYC), .busy(),
      .done(diag_done));
////////////////////////////////////////////////////////////////////////////
   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         master_ff    <= 1'b1;
         irq_ff       <= 1'b0;
         dev1_seen_ff <= 1'b0;
         first_cmd_ff <= 1'b0;
         pres_win_ff  <= 1'b0;
         pdiag_drv_ff <= 1'b0;
         srst_d_ff    <= 1'b0;
         busy_ff      <= 1'b1;
         devctl_ff    <= 8'h00;
         drvhd_dev_ff <= 1'b0;
      end else begin
         srst_d_ff <= srst_now;
         if (rst_rel)
            master_ff <= I_CSEL_MODE ? ~csel_s : master_ff;
         // set wins over clear
         if (I_IRQ_SET)
            irq_ff <= 1'b1;
         else if (stat_rd | cmd_wr | in_rst)
            irq_ff <= 1'b0;
         if (in_rst) begin
            devctl_ff    <= 8'h00;
            drvhd_dev_ff <= 1'b0;
            busy_ff      <= 1'b1;
         end else begin
            if (ctl_wr)
               devctl_ff <= dd_s[7:0];
            if (drvhd_wr)
               drvhd_dev_ff <= dd_s[`ATADI_B_DEV];
            if (srst_now)
               busy_ff <= 1'b1;
            else if (bsy_done)
               busy_ff <= 1'b0;
         end
         // device 1 asserts presence until first valid command
         if (rst_rel) begin
            pres_win_ff  <= 1'b1;
            first_cmd_ff <= 1'b0;
         end else if (I_CMD_ACCEPT) begin
            pres_win_ff  <= 1'b0;
            first_cmd_ff <= 1'b1;
         end else if (pres_done & ~first_cmd_ff) begin
            pres_win_ff <= 1'b1;
         end
         // device 0 watches presence for the wait window
         if (rst_rel)
            dev1_seen_ff <= 1'b0;
         else if (wp_busy & dasp_s)
            dev1_seen_ff <= 1'b1;
         // device 1 diagnostic: release then assert when done
         if (in_rst | any_rel | diag_cmd)
            pdiag_drv_ff <= 1'b0;
         else if ((diag_done | I_DIAG_DONE) & ~busy_ff)
            pdiag_drv_ff <= 1'b1;
      end
   end
////////////////////////////////////////////////////////////////////////////
   // read mux; only low byte for registers
   reg [15:0] rd_mux;
   always @* begin
      rd_mux = 16'h0000;
      if (cs0_s & ~cs1_s) begin
         case (da_s)
            `ATADI_A_DATA:    rd_mux = I_RD_DATA;
            `ATADI_A_ERRFEAT: rd_mux = {8'h00, I_ERROR};
            `ATADI_A_STATCMD: rd_mux = {8'h00, busy_ff ?
               (I_STATUS | 8'h80) : I_STATUS};
            default:          rd_mux = {8'h00, I_STATUS};
         endcase
      end else if (cs1_s & ~cs0_s) begin
         case (da_s)
            `ATADI_A_ALTCTL: rd_mux = {8'h00, busy_ff ?
               (I_STATUS | 8'h80) : I_STATUS};
            `ATADI_A_DRVADR: rd_mux = {8'h00, 2'h0, ~pdiag_s,
               ~drvhd_dev_ff, drvhd_dev_ff,
               3'h0};
            default:         rd_mux = 16'h0000;
         endcase
      end
   end
////////////////////////////////////////////////////////////////////////////
   // udma data-in strobe toggles every clock while host ready, device ready and no stop
   reg dstb_ff;
   always @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_DD          <= 16'h0000;
         O_DD_OE       <= 1'b0;
         O_IORDY       <= 1'b1;
         O_IORDY_OE    <= 1'b0;
         O_INTRQ       <= 1'b0;
         O_INTRQ_OE    <= 1'b0;
         O_DMARQ       <= 1'b0;
         O_DASP_OE     <= 1'b0;
         O_PDIAG_OE    <= 1'b0;
         O_IS_MASTER   <= 1'b1;
         O_DEV1_ABSENT <= 1'b0;
         O_BUSY        <= 1'b1;
         O_DATA_WR     <= 1'b0;
         O_DATA_RD     <= 1'b0;
         O_UDMA_STB    <= 1'b0;
         O_UDMA_STOP   <= 1'b0;
         O_WR_DATA     <= 16'h0000;
         O_CMD         <= 8'h00;
         O_CMD_STB     <= 1'b0;
         O_DEV1_STAT   <= 8'h00;
         O_FEAT        <= 8'h00;
         O_DEVCTL      <= 8'h00;
         dstb_ff       <= 1'b0;
      end else begin
         O_IS_MASTER <= master_ff;
         O_BUSY      <= busy_ff;
         O_DEVCTL    <= devctl_ff;
         O_DATA_WR   <= 1'b0;
         O_DATA_RD   <= 1'b0;
         O_CMD_STB   <= 1'b0;
         O_UDMA_STB  <= 1'b0;
         if (iow_rise & cs0_s & ~cs1_s) begin
            O_WR_DATA <= dd_s;
            if (da_s == `ATADI_A_DATA)
               O_DATA_WR <= 1'b1;
            if (da_s == `ATADI_A_ERRFEAT)
               O_FEAT <= dd_s[7:0];
            if (da_s == `ATADI_A_STATCMD) begin
               O_CMD     <= dd_s[7:0];
               O_CMD_STB <= 1'b1;
            end
         end
         if (ior_rise & cs0_s & ~cs1_s & (da_s == `ATADI_A_DATA))
            O_DATA_RD <= 1'b1;
         if (hstb_edg) begin
            O_WR_DATA  <= dd_s;
            O_UDMA_STB <= 1'b1;
         end
         // stop is high on the pin; host ready is low-active
         O_UDMA_STOP <= udma & ~iow_s;
         // drive bus while read strobe low with this drive selected, or on udma data-in
         if (udma & I_UDMA_IN) begin
            O_DD_OE <= 1'b1;
            if (ior_s & I_DMA_RDY & iow_s) begin
               O_DD       <= I_RD_DATA;
               dstb_ff    <= ~dstb_ff;
               O_UDMA_STB <= 1'b1;
            end
         end else begin
            O_DD_OE <= ior_s & ~ack_s & (cs0_s ^ cs1_s) & sel_dev;
            O_DD    <= rd_mux;
         end
         // ready line: wait flag at strobe fall, or udma meanings
         if (udma) begin
            O_IORDY_OE <= 1'b1;
            O_IORDY    <= I_UDMA_IN ? dstb_ff : ~I_DMA_RDY;
         end else if (iow_fall | ior_fall) begin
            O_IORDY_OE <= I_WAIT;
            O_IORDY    <= ~I_WAIT;
         end else if (~(iow_s | ior_s) | ~I_WAIT) begin
            O_IORDY_OE <= 1'b0;
            O_IORDY    <= 1'b1;
         end
         O_DMARQ    <= I_DMA_RDY;
         O_INTRQ_OE <= sel_dev & ~devctl_ff[`ATADI_B_NIEN];
         O_INTRQ    <= irq_ff;
         O_DASP_OE  <= master_ff ? I_ACTIVE :
                       ((pres_win_ff & ~first_cmd_ff) |
                        (first_cmd_ff & I_ACTIVE));
         O_PDIAG_OE <= ~master_ff & pdiag_drv_ff;
         if (wp_done)
            O_DEV1_ABSENT <= master_ff & ~dev1_seen_ff;
         if (wp_done & master_ff & ~dev1_seen_ff)
            O_DEV1_STAT <= `ATADI_STAT_ZERO;
      end
   end
endmodule // atadi_top

/* tb/atadi_top_asserts.sv */
`timescale 1ns/10ps
module atadi_chk (
   // clock, reset and cable pins
   input logic       I_CLK, I_RESETN, I_PIN_RESETN, I_CS0N, I_CS1N,
   input logic       I_DIOWN, I_DIORN, I_DMACKN,
   input logic [2:0] I_DA,
   // drive processor side
   input logic       I_CMD_ACCEPT, I_ACTIVE, I_WAIT,
   input logic       I_DMA_RDY, I_UDMA_EN, I_UDMA_IN,
   // outputs
   input logic       O_BUSY, O_DMARQ, O_INTRQ, O_INTRQ_OE, O_DD_OE,
   input logic       O_CMD_STB, O_DASP_OE, O_IS_MASTER, O_UDMA_STB,
   input logic       O_IORDY_OE,
   input logic [7:0] O_DEVCTL
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);
   ///////////////////////////////////////////////////////////////////
   // 9.5 us from the pin edge, synchroniser included
   a_busy_clear: assert property (
      $rose(I_PIN_RESETN) |-> ##[1:95] !O_BUSY)
      else $error("busy stayed set after reset");
   a_dma_request: assert property (
      $rose(I_DMA_RDY) |=> O_DMARQ)
      else $error("dma request late");
   a_intr_gated: assert property (
      O_INTRQ_OE |-> !O_DEVCTL[1])
      else $error("interrupt driven while disabled");
   a_irq_status: assert property (
      $rose(O_DD_OE) && I_DMACKN && !I_CS0N && I_DA == 3'h7
      |-> ##[0:12] !O_INTRQ)
      else $error("status read left irq set");
   a_cmd_strobe: assert property (
      $rose(I_DIOWN) && I_DMACKN && !I_CS0N && I_CS1N && I_DA == 3'h7
      |-> ##[1:5] O_CMD_STB)
      else $error("command write not captured");
   a_dasp_release: assert property (
      I_CMD_ACCEPT && !O_IS_MASTER && !I_ACTIVE |-> ##[1:3] !O_DASP_OE)
      else $error("presence not released");
   a_udma_edge: assert property (
      !I_DMACKN && I_UDMA_EN && !I_UDMA_IN && $changed(I_DIORN)
      |-> ##[1:5] O_UDMA_STB)
      else $error("host strobe edge lost");
   a_wait_state: assert property (
      $fell(I_DIORN) && I_WAIT && I_DMACKN |-> ##[1:5] O_IORDY_OE)
      else $error("ready not pulled for wait");
endmodule // atadi_chk

bind atadi_top atadi_chk i_atadi_chk (.*);

/* tb/atadi_host.sv */
`timescale 1ns/10ps
// host stand-in; strobes kept slow for the pin synchroniser
module atadi_host (
   input  logic        clk,
   input  logic [15:0] dd_in,
   output logic        rst_n, cs0n, cs1n, diown, diorn, dmackn,
   output logic [15:0] dd,
   output logic [2:0]  da
);
   initial begin
      rst_n = 0;
      {cs0n, cs1n, diown, diorn, dmackn} = 5'h1f;
      dd = 16'h0000;
      da = 3'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic hreset();
      tick(1);
      rst_n = 0;
      tick(260);
      rst_n = 1;
   endtask
   task automatic sel(input logic c1, input logic [2:0] a);
      tick(1);
      cs0n = c1;
      cs1n = !c1;
      da = a;
   endtask
   task automatic wr(input logic c1, input logic [2:0] a,
                     input logic [15:0] d);
      sel(c1, a);
      dd = d;
      tick(2);
      diown = 0;
      tick(8);
      diown = 1;
      tick(4);
      {cs0n, cs1n} = 2'h3;
      dd = ~dd; // released bus must not keep the last value
   endtask
   task automatic rd(input logic c1, input logic [2:0] a,
                     output logic [15:0] d);
      sel(c1, a);
      tick(2);
      diorn = 0;
      tick(8);
      d = dd_in;
      diorn = 1;
      tick(4);
      {cs0n, cs1n} = 2'h3;
   endtask
   task automatic udma_out(input logic [15:0] w [4]);
      tick(1);
      dmackn = 0;
      tick(4);
      diown = 0;
      for (int i = 0; i < 4; i++) begin
         dd = w[i];
         tick(2);
         diorn = !diorn;
         tick(4);
      end
      diown = 1;
      tick(4);
      dmackn = 1;
      dd = ~dd;
   endtask
   task automatic udma_in(output logic [15:0] d);
      tick(1);
      dmackn = 0;
      tick(4);
      diown = 0;
      diorn = 0;
      tick(8);
      d = dd_in;
      diorn = 1;
      tick(4);
      diown = 1;
      tick(4);
      dmackn = 1;
   endtask
endmodule // atadi_host

/* tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
   logic        I_CLK, I_RESETN, I_PIN_RESETN, I_CS0N, I_CS1N, I_DIOWN;
   logic        I_DIORN, I_DMACKN, I_CSEL, I_CSEL_MODE, I_IRQ_SET, I_WAIT;
   logic        I_CMD_ACCEPT, I_ACTIVE, I_DIAG_DONE, I_DMA_RDY, I_UDMA_EN;
   logic        I_UDMA_IN, O_DD_OE, O_IORDY, O_IORDY_OE, O_INTRQ, O_DMARQ;
   logic        O_INTRQ_OE, O_DASP_OE, O_PDIAG_OE, O_IS_MASTER, O_BUSY;
   logic        O_DEV1_ABSENT, O_DATA_WR, O_DATA_RD, O_UDMA_STB, O_CMD_STB;
   logic        O_UDMA_STOP, waited, stopped;
   logic [2:0]  I_DA;
   logic [7:0]  I_STATUS, I_ERROR, O_CMD, O_DEV1_STAT, O_FEAT, O_DEVCTL;
   logic [15:0] I_DD, I_RD_DATA, O_DD, O_WR_DATA, h_dd, rd_d;
   logic [15:0] got [4];
   int          n_errors, comparisons, n_stb;
   // open-drain lines with pull-ups; only this drive pulls
   wire         I_DASPN = !O_DASP_OE;
   wire         I_PDIAGN = !O_PDIAG_OE;
   assign I_DD = O_DD_OE ? O_DD : h_dd;
   ///////////////////////////////////////////////////////////////////
   atadi_top #(.PRES_CYC(32'd50), .WAITP_CYC(32'd60), .DREL_CYC(32'd10))
      i_atadi_top (.I_CLK, .I_RESETN, .I_PIN_RESETN, .I_DD, .O_DD,
      .O_DD_OE, .I_DA, .I_CS0N, .I_CS1N, .I_DIOWN, .I_DIORN, .I_DMACKN,
      .I_CSEL, .O_IORDY, .O_IORDY_OE, .O_INTRQ, .O_INTRQ_OE, .O_DMARQ,
      .I_DASPN, .O_DASP_OE, .I_PDIAGN, .O_PDIAG_OE, .I_CSEL_MODE,
      .I_IRQ_SET, .I_CMD_ACCEPT, .I_ACTIVE, .I_DIAG_DONE, .I_WAIT,
      .I_DMA_RDY, .I_UDMA_EN, .I_UDMA_IN, .I_RD_DATA, .I_STATUS, .I_ERROR,
      .O_IS_MASTER, .O_DEV1_ABSENT, .O_BUSY, .O_DATA_WR, .O_DATA_RD,
      .O_UDMA_STB, .O_UDMA_STOP, .O_WR_DATA, .O_CMD, .O_CMD_STB,
      .O_DEV1_STAT, .O_FEAT, .O_DEVCTL);
   atadi_host i_atadi_host (.clk(I_CLK), .dd_in(I_DD),
      .rst_n(I_PIN_RESETN), .dd(h_dd), .da(I_DA), .cs0n(I_CS0N),
      .cs1n(I_CS1N), .diown(I_DIOWN), .diorn(I_DIORN), .dmackn(I_DMACKN));
   initial begin
      I_CLK = 0;
      forever #50 I_CLK = !I_CLK;
   end
   always @(posedge I_CLK) begin
      if (O_UDMA_STB === 1'b1 && n_stb < 4) got[n_stb] <= O_WR_DATA;
      if (O_UDMA_STB === 1'b1) n_stb <= n_stb + 1;
      if (O_IORDY_OE === 1'b1) waited <= 1;
      if (O_UDMA_STOP === 1'b1) stopped <= 1;
   end
   ///////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] g, e, input string m);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge I_CLK);
      s = 1;
      @(negedge I_CLK);
      s = 0;
   endtask
   task automatic t_role(input logic cs);
      I_CSEL = cs;
      i_atadi_host.hreset();
      chk(O_BUSY, 1, "busy");
      for (int i = 0; i < 95 && O_BUSY === 1'b1; i++) @(negedge I_CLK);
      chk(O_BUSY, 0, "busy clear");
      chk(O_IS_MASTER, !cs, "role");
      chk(O_DEVCTL, 0, "devctl");
      if (!cs) begin
         chk(O_DEV1_ABSENT, 1, "absent");
         chk(O_DEV1_STAT, 0, "dev1 stat");
      end
      $display("role test done");
   endtask
   task automatic t_slave();
      chk(O_DASP_OE, 1, "presence");
      chk(O_PDIAG_OE, 0, "diag busy");
      pulse(I_DIAG_DONE);
      repeat (4) @(negedge I_CLK);
      chk(O_PDIAG_OE, 1, "diag done");
      i_atadi_host.wr(0, 3'h7, 16'h0090);
      chk(O_CMD, 8'h90, "diag cmd");
      repeat (12) @(negedge I_CLK);
      chk(O_PDIAG_OE, 0, "diag rerun");
      pulse(I_CMD_ACCEPT);
      repeat (4) @(negedge I_CLK);
      chk(O_DASP_OE, 0, "dasp off");
      I_ACTIVE = 1;
      repeat (4) @(negedge I_CLK);
      chk(O_DASP_OE, 1, "activity");
      I_ACTIVE = 0;
      $display("slave test done");
   endtask
   task automatic t_regs();
      i_atadi_host.wr(1, 3'h6, 16'h0008);
      chk(O_DEVCTL, 8'h08, "devctl");
      i_atadi_host.wr(0, 3'h1, 16'h00a5);
      chk(O_FEAT, 8'ha5, "features");
      i_atadi_host.wr(0, 3'h6, 16'h00b0);
      pulse(I_IRQ_SET);
      repeat (4) @(negedge I_CLK);
      chk({O_INTRQ_OE, O_INTRQ}, 2'h3, "irq out");
      i_atadi_host.rd(1, 3'h6, rd_d);
      chk(rd_d[7:0], I_STATUS, "alt status");
      chk(O_INTRQ, 1, "irq kept");
      I_WAIT = 1;
      i_atadi_host.rd(0, 3'h7, rd_d);
      I_WAIT = 0;
      chk(waited, 1, "wait");
      chk(rd_d[7:0], I_STATUS, "status");
      chk(O_INTRQ, 0, "irq read");
      i_atadi_host.rd(0, 3'h1, rd_d);
      chk(rd_d[7:0], I_ERROR, "error");
      i_atadi_host.rd(0, 3'h0, rd_d);
      chk(rd_d, I_RD_DATA, "data");
      pulse(I_IRQ_SET);
      i_atadi_host.wr(0, 3'h7, 16'h00ec);
      chk(O_INTRQ, 0, "irq cmd");
      pulse(I_IRQ_SET);
      i_atadi_host.wr(1, 3'h6, 16'h000a);
      chk(O_INTRQ_OE, 0, "irq off");
      i_atadi_host.wr(1, 3'h6, 16'h0008);
      i_atadi_host.wr(0, 3'h6, 16'h00a0);
      chk(O_INTRQ_OE, 0, "other drive");
      $display("register test done");
   endtask
   task automatic t_dma();
      logic [15:0] w [4] = '{16'h1234, 16'hfedc, 16'h0001, 16'h8000};
      I_DMA_RDY = 1;
      repeat (2) @(negedge I_CLK);
      chk(O_DMARQ, 1, "dmarq");
      I_UDMA_EN = 1;
      n_stb = 0;
      i_atadi_host.udma_out(w);
      chk(n_stb[15:0], 4, "words");
      for (int i = 0; i < 4; i++) begin
         chk(got[i], w[i], "udma");
      end
      chk(stopped, 1, "stop");
      I_UDMA_IN = 1;
      n_stb = 0;
      i_atadi_host.udma_in(rd_d);
      chk(rd_d, I_RD_DATA, "udma in");
      chk(n_stb >= 6 && n_stb <= 10, 1, "in words");
      I_DMA_RDY = 0;
      {I_UDMA_EN, I_UDMA_IN} = 2'h0;
      repeat (2) @(negedge I_CLK);
      chk(O_DMARQ, 0, "dmarq off");
      $display("dma test done");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ///////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge I_CLK);
      $display("BAD %0t watchdog", $time);
      n_errors++;
      tally_and_finish();
   end
   initial begin
      {I_RESETN, I_CSEL, I_IRQ_SET, I_CMD_ACCEPT, I_ACTIVE} = 5'h00;
      {I_DIAG_DONE, I_WAIT, I_DMA_RDY, I_UDMA_EN, I_UDMA_IN} = 5'h00;
      I_CSEL_MODE = 1;
      I_RD_DATA = 16'hc3a5;
      I_STATUS = 8'h50;
      I_ERROR = 8'h04;
      waited = 0;
      stopped = 0;
      n_stb = 0;
      repeat (2) @(negedge I_CLK);
      I_RESETN = 1;
      t_role(0);
      t_role(1);
      t_slave();
      t_regs();
      t_dma();
      tally_and_finish();
   end
endmodule // testbench
